/* File: core/xmpc_pkg.sv */
// Purpose: constants for the external memory port control block
// Assumes: 32-bit AXI4-Lite access
// Notes:   byte offsets, one word per register
package xmpc_pkg;
   localparam int unsigned AXI_AW          = 32;
   localparam int unsigned AXI_DW          = 32;
   localparam int unsigned PORT_AW         = 16;
   localparam int unsigned PORT_DW         = 24;
   localparam int unsigned WAIT_W_DEF      = 4;
   localparam int unsigned WAIT_DEF        = 0;
   // register offsets, low address byte
   localparam logic [7:0] OFF_OMR         = 8'h00;
   localparam logic [7:0] OFF_PORT_CTRL   = 8'h04;
   localparam logic [7:0] OFF_IRQ_CFG     = 8'h08;
   localparam logic [7:0] OFF_STATUS      = 8'h0C;
   // operating mode register fields
   localparam int unsigned OMR_MODE_LSB    = 0;
   localparam int unsigned OMR_WAIT_MODE   = 7;
   // irq config: 1 = falling edge
   localparam int unsigned IRQ_EDGE_A      = 0;
   localparam int unsigned IRQ_EDGE_B      = 1;
   localparam logic [1:0]  IRQ_CFG_RST     = 2'h0;
   // status fields
   localparam int unsigned STS_GRANTED     = 0;
   localparam int unsigned STS_BUSY        = 1;
   localparam int unsigned STS_IRQ_LSB     = 2;
   localparam int unsigned STS_PIN_LSB     = 4;
   localparam int unsigned STS_REQ_PIN     = 6;
   localparam logic        OMR_WAIT_RST    = 1'b0;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

/* File: core/xmpc_port_ctrl.sv */
// Purpose: expansion port control, bus release, boot mode, irq pins
// Assumes: all inputs synchronous to aclk; pads resolved outside
// Notes:   registers over AXI4-Lite; core side is a request/ack port
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Functional notes
// - address pins hold between external accesses
// - bit 7 clear: data bus floats while grant is asserted
// - program select only on external program accesses
// - data select only on external data accesses
// - x/y select marks X or Y data access
// - read strobe while reading external memory
// - write strobe while writing external memory
// - selects, strobes, grant three-stated in reset
// - bit 7 clear, request: float port after instruction
// - bit 7 clear: grant only after port released
// - bit 7 set: request pin adds wait states
// - bit 7 set: grant pin strobes each access
// - mode pins latched as operating mode at reset exit
// - after reset mode pins are interrupt inputs A, B
// - each interrupt input level or falling edge, by software
// - software may rewrite operating mode
// - mode/irq pins are inputs in reset
// - reset initialises state, holds until release
module xmpc_port_ctrl #(
   parameter int unsigned WAIT_W   = xmpc_pkg::WAIT_W_DEF, // wait count width
   parameter int unsigned WAIT_DEF = xmpc_pkg::WAIT_DEF    // reset wait count
) (
   input  wire logic                        aclk,          // clock
   input  wire logic                        aresetn,       // sync reset
   input  wire logic [xmpc_pkg::AXI_AW-1:0] s_axi_awaddr,  // write address
   input  wire logic                        s_axi_awvalid, // aw valid
   output logic                             s_axi_awready, // aw ready
   input  wire logic [xmpc_pkg::AXI_DW-1:0] s_axi_wdata,   // write data
   input  wire logic [3:0]                  s_axi_wstrb,   // byte enables
   input  wire logic                        s_axi_wvalid,  // w valid
   output logic                             s_axi_wready,  // w ready
   output logic [1:0]                       s_axi_bresp,   // write resp
   output logic                             s_axi_bvalid,  // b valid
   input  wire logic                        s_axi_bready,  // b ready
   input  wire logic [xmpc_pkg::AXI_AW-1:0] s_axi_araddr,  // read address
   input  wire logic                        s_axi_arvalid, // ar valid
   output logic                             s_axi_arready, // ar ready
   output logic [xmpc_pkg::AXI_DW-1:0]      s_axi_rdata,   // read data
   output logic [1:0]                       s_axi_rresp,   // read resp
   output logic                             s_axi_rvalid,  // r valid
   input  wire logic                        s_axi_rready,  // r ready
   input  wire logic                        core_req,      // access request
   input  wire logic                        core_write,    // 1 write, 0 read
   input  wire logic                        core_data_space, // 1 data, 0 prog
   input  wire logic                        core_y_space,  // 1 Y, 0 X
   input  wire logic [xmpc_pkg::PORT_AW-1:0] core_addr,    // access address
   input  wire logic [xmpc_pkg::PORT_DW-1:0] core_wdata,   // write data
   input  wire logic                        core_instr_boundary, // instr done
   output logic                             core_ready,    // request taken
   output logic                             core_ack,      // access done
   output logic [xmpc_pkg::PORT_DW-1:0]     core_rdata,    // read data
   input  wire logic [1:0]                  irq_ack,       // clear edge irq
   output logic [1:0]                       irq_request,   // irq B,A to core
   output logic [1:0]                       operating_mode, // mode bits
   output logic                             wait_mode_en,  // mode bit 7
   output logic [xmpc_pkg::PORT_AW-1:0]     port_address_bus, // address pins
   output logic                             port_address_oe,  // address oe
   output logic [xmpc_pkg::PORT_DW-1:0]     port_data_out, // data pins out
   input  wire logic [xmpc_pkg::PORT_DW-1:0] port_data_in, // data pins in
   output logic                             port_data_oe,  // data oe
   output logic                             program_space_select_n, // prog
   output logic                             data_space_select_n, // data
   output logic                             x_space_select, // 1 X, 0 Y
   output logic                             read_strobe_n, // read strobe
   output logic                             write_strobe_n, // write strobe
   output logic                             port_control_oe, // control oe
   output logic                             bus_grant_out_n, // grant/strobe
   output logic                             bus_grant_oe,  // grant pin oe
   input  wire logic                        external_master_request_n, // req
   input  wire logic                        boot_mode_pin_a, // mode/irq A
   input  wire logic                        boot_mode_pin_b  // mode/irq B
);
   import xmpc_pkg::*;

   typedef enum logic [2:0] {
      XMPC_IDLE,
      XMPC_ACCESS,
      XMPC_RELEASE,
      XMPC_GRANTED,
      XMPC_RESUME
   } xmpc_state_t;

   typedef struct packed {
      xmpc_state_t        st;
      logic [WAIT_W-1:0]  wcnt;
      logic [WAIT_W-1:0]  wait_cfg;
      logic               acc_write;
      logic [PORT_AW-1:0] addr;
      logic [PORT_DW-1:0] wdata;
      logic [PORT_DW-1:0] rdata;
      logic               ack;
      logic               ps_n;
      logic               ds_n;
      logic               xsel;
      logic               rd_n;
      logic               wr_n;
      logic               grant_n;
      logic               ctl_oe;
      logic               data_oe;
      logic [1:0]         mode;
      logic               wait_mode;
      logic [1:0]         irq_edge;
      logic [1:0]         pin_d;
      logic [1:0]         irq_pend;
      logic [1:0]         irq_req;
      logic               aw_have;
      logic [7:0]         aw_addr;
      logic               w_have;
      logic [AXI_DW-1:0]  w_data;
      logic [3:0]         w_strb;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               rvalid;
      logic [AXI_DW-1:0]  rdata_axi;
      logic [1:0]         rresp;
   } xmpc_regs_t;

   if (WAIT_W < 1 || WAIT_W > 16 || WAIT_DEF >= (1 << WAIT_W)) begin : g_chk
      $error("WAIT_W or WAIT_DEF out of range");
   end

   xmpc_regs_t r;
   xmpc_regs_t next_r;

   // request pin is the wait input when bit 7 set
   logic       stall_input_n;
   logic       access_strobe_n;
   logic [1:0] pins;
   logic [1:0] fall;
   logic       release_go;
   logic       take_req;
   logic       stalled;
   logic       aw_fire;
   logic       w_fire;
   logic       ar_fire;
   logic       do_write;
   logic [AXI_DW-1:0] rd_word;
   logic       rd_hit;
   logic       wr_hit;

   assign stall_input_n = external_master_request_n;
   assign pins          = {boot_mode_pin_b, boot_mode_pin_a};
   assign fall          = r.pin_d & ~pins;

   ////////////////////////////////////////////////////////////////////
   // register read mux

   always_comb begin
      rd_word = '0;
      rd_hit  = 1'b1;
      unique case (s_axi_araddr[7:0])
         OFF_OMR: begin
            rd_word[OMR_MODE_LSB +: 2] = r.mode;
            rd_word[OMR_WAIT_MODE]     = r.wait_mode;
         end
         OFF_PORT_CTRL: begin
            rd_word[WAIT_W-1:0] = r.wait_cfg;
         end
         OFF_IRQ_CFG: begin
            rd_word[1:0] = r.irq_edge;
         end
         OFF_STATUS: begin
            rd_word[STS_GRANTED]       = (r.st == XMPC_GRANTED);
            rd_word[STS_BUSY]          = (r.st == XMPC_ACCESS);
            rd_word[STS_IRQ_LSB +: 2]  = r.irq_req;
            rd_word[STS_PIN_LSB +: 2]  = pins;
            rd_word[STS_REQ_PIN]       = external_master_request_n;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   assign wr_hit = (r.aw_addr == OFF_OMR) || (r.aw_addr == OFF_PORT_CTRL)
                || (r.aw_addr == OFF_IRQ_CFG) || (r.aw_addr == OFF_STATUS);

   assign aw_fire  = s_axi_awvalid && s_axi_awready;
   assign w_fire   = s_axi_wvalid && s_axi_wready;
   assign ar_fire  = s_axi_arvalid && s_axi_arready;
   assign do_write = r.aw_have && r.w_have && !r.bvalid;

   // release only between instructions
   assign release_go = !r.wait_mode && !external_master_request_n
                    && core_instr_boundary;
   assign take_req   = (r.st == XMPC_IDLE) && !release_go && core_req;
   assign stalled    = r.wait_mode && !stall_input_n;

   ////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      next_r     = r;
      next_r.ack = 1'b0;

      // mode pins reused as irq inputs
      next_r.pin_d = pins;
      for (int i = 0; i < 2; i++) begin
         // new edge beats same-cycle ack
         next_r.irq_pend[i] = r.irq_edge[i]
                            && (fall[i] || (r.irq_pend[i] && !irq_ack[i]));
         next_r.irq_req[i]  = r.irq_edge[i] ? next_r.irq_pend[i]
                                            : !pins[i];
      end

      // AXI4-Lite slave
      if (aw_fire) begin
         next_r.aw_have = 1'b1;
         next_r.aw_addr = s_axi_awaddr[7:0];
      end
      if (w_fire) begin
         next_r.w_have = 1'b1;
         next_r.w_data = s_axi_wdata;
         next_r.w_strb = s_axi_wstrb;
      end
      if (do_write) begin
         next_r.aw_have = 1'b0;
         next_r.w_have  = 1'b0;
         next_r.bvalid  = 1'b1;
         next_r.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
         // fields in byte lane 0; status read only
         if (r.w_strb[0]) begin
            unique case (r.aw_addr)
               OFF_OMR: begin
                  next_r.mode      = r.w_data[OMR_MODE_LSB +: 2];
                  next_r.wait_mode = r.w_data[OMR_WAIT_MODE];
               end
               OFF_PORT_CTRL: begin
                  next_r.wait_cfg = r.w_data[WAIT_W-1:0];
               end
               OFF_IRQ_CFG: begin
                  next_r.irq_edge = r.w_data[1:0];
               end
               default: begin
               end
            endcase
         end
      end
      if (r.bvalid && s_axi_bready) begin
         next_r.bvalid = 1'b0;
      end
      if (ar_fire) begin
         next_r.rvalid    = 1'b1;
         next_r.rdata_axi = rd_word;
         next_r.rresp     = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (r.rvalid && s_axi_rready) begin
         next_r.rvalid = 1'b0;
      end

      // port sequencer
      unique case (r.st)
         XMPC_IDLE: begin
            if (release_go) begin
               next_r.st      = XMPC_RELEASE;
               next_r.ctl_oe  = 1'b0;
               next_r.data_oe = 1'b0;
            end else if (core_req) begin
               next_r.st        = XMPC_ACCESS;
               next_r.wcnt      = r.wait_cfg;
               next_r.acc_write = core_write;
               next_r.addr      = core_addr;
               next_r.wdata     = core_wdata;
               next_r.ps_n      = core_data_space;
               next_r.ds_n      = !core_data_space;
               next_r.xsel      = core_data_space ? !core_y_space
                                                  : r.xsel;
               next_r.rd_n      = core_write;
               next_r.wr_n      = !core_write;
               next_r.data_oe   = core_write;
               next_r.grant_n   = !r.wait_mode;
            end
         end
         XMPC_ACCESS: begin
            if (r.wcnt != '0) begin
               next_r.wcnt = r.wcnt - 1'b1;
            end else if (!stalled) begin
               next_r.st      = XMPC_IDLE;
               next_r.ack     = 1'b1;
               next_r.rdata   = r.acc_write ? r.rdata : port_data_in;
               next_r.ps_n    = 1'b1;
               next_r.ds_n    = 1'b1;
               next_r.rd_n    = 1'b1;
               next_r.wr_n    = 1'b1;
               next_r.data_oe = 1'b0;
               next_r.grant_n = 1'b1;
            end
         end
         XMPC_RELEASE: begin
            // pins already floating, acknowledge now
            next_r.st      = XMPC_GRANTED;
            next_r.grant_n = 1'b0;
         end
         XMPC_GRANTED: begin
            if (external_master_request_n || r.wait_mode) begin
               next_r.st      = XMPC_RESUME;
               next_r.grant_n = 1'b1;
            end
         end
         XMPC_RESUME: begin
            // grant off one cycle before driving again
            next_r.st     = XMPC_IDLE;
            next_r.ctl_oe = 1'b1;
         end
      endcase

      if (!aresetn) begin
         next_r          = '0;
         next_r.st       = XMPC_IDLE;
         next_r.wait_cfg = WAIT_W'(WAIT_DEF);
         next_r.ps_n     = 1'b1;
         next_r.ds_n     = 1'b1;
         next_r.xsel     = 1'b1;
         next_r.rd_n     = 1'b1;
         next_r.wr_n     = 1'b1;
         next_r.grant_n  = 1'b1;
         next_r.ctl_oe   = 1'b1;
         next_r.irq_edge = IRQ_CFG_RST;
         next_r.wait_mode = OMR_WAIT_RST;
         // last sample before release is kept
         next_r.mode     = pins;
         next_r.pin_d    = pins;
      end
   end

   always_ff @(posedge aclk) begin
      r <= next_r;
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   assign access_strobe_n = r.grant_n;

   assign s_axi_awready = !r.aw_have && !r.bvalid;
   assign s_axi_wready  = !r.w_have && !r.bvalid;
   assign s_axi_bvalid  = r.bvalid;
   assign s_axi_bresp   = r.bresp;
   assign s_axi_arready = !r.rvalid;
   assign s_axi_rvalid  = r.rvalid;
   assign s_axi_rdata   = r.rdata_axi;
   assign s_axi_rresp   = r.rresp;

   assign core_ready     = take_req;
   assign core_ack       = r.ack;
   assign core_rdata     = r.rdata;
   assign irq_request    = r.irq_req;
   assign operating_mode = r.mode;
   assign wait_mode_en   = r.wait_mode;

   // address holds between accesses
   assign port_address_bus = r.addr;
   assign port_address_oe  = r.ctl_oe && aresetn;
   assign port_data_out    = r.wdata;
   // data off while released
   assign port_data_oe     = r.data_oe && r.ctl_oe && aresetn;

   assign program_space_select_n = r.ps_n;
   assign data_space_select_n    = r.ds_n;
   assign x_space_select         = r.xsel;
   assign read_strobe_n          = r.rd_n;
   assign write_strobe_n         = r.wr_n;
   // reset pin gates, so pins float at once
   assign port_control_oe        = r.ctl_oe && aresetn;
   assign bus_grant_out_n        = access_strobe_n;
   assign bus_grant_oe           = aresetn;

endmodule
`default_nettype wire

/* File: verif/xmpc_memory_model.sv */
// Purpose: external memory and outside master model
// Assumes: same clock as the port block
// Notes:   one 64-word memory, a 16-word region per space
`timescale 1ns/10ps
`default_nettype none
module xmpc_memory_model (
   input  wire logic                         aclk,                // clock
   input  wire logic [xmpc_pkg::PORT_AW-1:0] port_address_bus,    // address
   input  wire logic [xmpc_pkg::PORT_DW-1:0] port_data_out,       // data out
   input  wire logic                         port_data_oe,        // data oe
   input  wire logic                         data_space_select_n, // data
   input  wire logic                         x_space_select,      // x/y
   input  wire logic                         read_strobe_n,       // read
   input  wire logic                         write_strobe_n,      // write
   input  wire logic [3:0]                   stall_len,           // waits
   input  wire logic                         master_request_n,    // master
   output logic [xmpc_pkg::PORT_DW-1:0]      port_data_in,        // data in
   output logic                              external_master_request_n // pin
);
   import xmpc_pkg::*;
   logic [PORT_DW-1:0] mem [0:63];
   logic [PORT_DW-1:0] last_q = '0;
   logic [3:0]         stall_cnt = '0;
   logic [5:0]         idx;
   logic               idle;
   ////////////////////////////////////////
   assign idle = read_strobe_n && write_strobe_n;
   assign idx = data_space_select_n ? {2'h2, port_address_bus[3:0]} :
                {1'b0, x_space_select, port_address_bus[3:0]};
   always @(posedge aclk) begin
      last_q <= port_data_in;
      if (idle) begin
         stall_cnt <= stall_len;
      end else if (stall_cnt != 4'h0) begin
         stall_cnt <= stall_cnt - 4'h1;
      end
      if (!write_strobe_n && port_data_oe) begin
         mem[idx] <= port_data_out;
      end
   end
   // idle bus shows the inverse of the last cycle's value, so it toggles
   assign port_data_in = !read_strobe_n ? mem[idx] : ~last_q;
   assign external_master_request_n = master_request_n &&
                                      (idle || stall_cnt == 4'h0);
endmodule
`default_nettype wire

/* File: verif/xmpc_port_ctrl_checker.sv */
// Purpose: port timing and float checks
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound below, sees top ports only
`timescale 1ns/10ps
`default_nettype none
module xmpc_port_ctrl_checker (
   input wire logic                         aclk,                      // clk
   input wire logic                         aresetn,                   // rst
   input wire logic [xmpc_pkg::PORT_AW-1:0] port_address_bus,          // adr
   input wire logic                         port_data_oe,              // oe
   input wire logic                         port_control_oe,           // oe
   input wire logic                         program_space_select_n,    // ps
   input wire logic                         data_space_select_n,       // ds
   input wire logic                         read_strobe_n,             // rd
   input wire logic                         write_strobe_n,            // wr
   input wire logic                         bus_grant_out_n,           // bg
   input wire logic                         bus_grant_oe,              // oe
   input wire logic                         wait_mode_en,              // b7
   input wire logic                         external_master_request_n, // rq
   input wire logic                         core_instr_boundary        // ib
);
   import xmpc_pkg::*;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence strobing;
      !read_strobe_n || !write_strobe_n;
   endsequence
   addr_hold_a: assert property ($changed(port_address_bus) |-> strobing)
      else $error("address moved idle");
   grant_float_a: assert property (!wait_mode_en && !bus_grant_out_n |-> !port_data_oe)
      else $error("data driven in grant");
   prog_sel_a: assert property (!program_space_select_n |-> data_space_select_n ##0 strobing)
      else $error("bad program select");
   data_sel_a: assert property (!data_space_select_n |-> strobing)
      else $error("bad data select");
   rd_dir_a: assert property (!read_strobe_n |-> !port_data_oe && write_strobe_n)
      else $error("read with data driven");
   wr_dir_a: assert property (!write_strobe_n |-> port_data_oe)
      else $error("write without data");
   reset_float_a: assert property (disable iff (1'b0)
      !aresetn |-> !port_control_oe && !bus_grant_oe) else $error("driven in reset");
   release_point_a: assert property ($fell(port_control_oe) |->
      $past(core_instr_boundary) && !$past(external_master_request_n)) else $error("bad release");
   grant_after_a: assert property ($fell(bus_grant_out_n) ##0 !wait_mode_en |->
      !port_control_oe && !$past(port_control_oe)) else $error("grant before release");
   stall_hold_a: assert property (wait_mode_en ##0 !read_strobe_n ##0
      !external_master_request_n |=> !read_strobe_n) else $error("wait input ignored");
   bus_strobe_a: assert property (wait_mode_en ##0 strobing |-> !bus_grant_out_n)
      else $error("no bus strobe");
   resume_a: assert property ($rose(external_master_request_n) ##0 !bus_grant_out_n
      ##0 !wait_mode_en |=> bus_grant_out_n && !port_control_oe ##1 port_control_oe)
      else $error("bad resume");
endmodule
bind xmpc_port_ctrl xmpc_port_ctrl_checker xmpc_port_ctrl_checker_inst (.*);
`default_nettype wire

/* File: verif/external_memory_port_control_test.sv */
// Purpose: self-checking bench for the port block
// Assumes: 100 MHz clock, ten-cycle synchronous reset
// Notes:   tasks return at a falling edge
`timescale 1ns/10ps
`default_nettype none
module external_memory_port_control_test;
   import xmpc_pkg::*;
   logic        aclk, aresetn, master_request_n, core_req, core_write;
   logic        core_data_space, core_y_space, core_instr_boundary;
   logic        core_ready, core_ack, wait_mode_en, port_address_oe;
   logic        port_data_oe, program_space_select_n, data_space_select_n;
   logic        x_space_select, read_strobe_n, write_strobe_n, bus_grant_oe;
   logic        port_control_oe, bus_grant_out_n, external_master_request_n;
   logic        boot_mode_pin_a, boot_mode_pin_b, s_axi_awvalid, s_axi_wvalid;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
   logic [1:0]  s_axi_bresp, s_axi_rresp, irq_ack, irq_request, resp, sp;
   logic [1:0]  operating_mode;
   logic [3:0]  s_axi_wstrb, stall_len;
   logic [15:0] core_addr, port_address_bus;
   logic [23:0] core_wdata, core_rdata, port_data_out, port_data_in;
   logic [6:0]  snap;
   int          err_total, checked, cyc;
   xmpc_port_ctrl #(.WAIT_W(4), .WAIT_DEF(0)) xmpc_port_ctrl_inst (.*);
   xmpc_memory_model xmpc_memory_model_inst (.*);
   initial aclk = 1'b0;
   always #5 aclk = ~aclk;
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("checked %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
      do begin
         @(negedge aclk);
         aw_done = aw_done || s_axi_awready;
         w_done = w_done || s_axi_wready;
         @(posedge aclk);
         if (aw_done) s_axi_awvalid <= 1'b0;
         if (w_done) s_axi_wvalid <= 1'b0;
      end while (!(aw_done && w_done));
      do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
   endtask
   task automatic axi_rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      do @(negedge aclk); while (s_axi_arready !== 1'b1);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
   endtask
   task automatic core_acc(input logic wr, input logic [23:0] d);
      @(posedge aclk);
      {core_req, core_write, core_data_space, core_y_space} <= {1'b1, wr, sp};
      core_addr <= 16'h0003;
      core_wdata <= d;
      do @(negedge aclk); while (core_ready !== 1'b1);
      @(posedge aclk);
      core_req <= 1'b0;
      cyc = 0;
      do begin
         @(negedge aclk);
         cyc++;
         if (cyc == 1) snap = {program_space_select_n, data_space_select_n,
            x_space_select, read_strobe_n, write_strobe_n, bus_grant_out_n,
            port_data_oe};
      end while (core_ack !== 1'b1);
   endtask
   task automatic t_regs;
      axi_rd(OFF_OMR);
      chk(rd & 32'h83, 32'h01);
      axi_rd(OFF_PORT_CTRL);
      chk(rd, 32'h0);
      axi_wr(OFF_OMR, 32'h02);
      chk(operating_mode, 2'h2);
      chk(resp, RESP_OKAY);
      axi_rd(8'h40);
      chk(resp, RESP_SLVERR);
      $display("register test done");
   endtask
   task automatic t_access;
      axi_wr(OFF_PORT_CTRL, 32'h2);
      for (int j = 0; j < 6; j++) begin
         sp = (j % 3 == 0) ? 2'h0 : {1'b1, j % 3 == 2};
         core_acc(j < 3, 24'hC0FFE0 + j % 3);
         chk(snap[6:5], {sp[1], !sp[1]});
         if (sp[1]) chk(snap[4], !sp[0]);
         chk(snap[3:1], (j < 3) ? 3'h5 : 3'h3);
         chk(cyc, 4);
         if (j >= 3) chk(core_rdata, 24'hC0FFE0 + j % 3);
      end
      repeat (3) @(negedge aclk);
      chk(port_address_bus, 16'h0003);
      $display("access test done");
   endtask
   task automatic t_release;
      @(posedge aclk);
      core_instr_boundary <= 1'b0;
      master_request_n <= 1'b0;
      repeat (4) @(negedge aclk);
      chk(port_control_oe, 1'b1);
      @(posedge aclk);
      core_instr_boundary <= 1'b1;
      cyc = 0;
      do begin
         @(negedge aclk);
         cyc++;
      end while (bus_grant_out_n !== 1'b0);
      chk(cyc, 3);
      chk({port_data_oe, port_address_oe, port_control_oe}, 3'h0);
      @(posedge aclk);
      master_request_n <= 1'b1;
      repeat (2) @(negedge aclk);
      chk({bus_grant_out_n, port_control_oe}, 2'h2);
      @(negedge aclk);
      chk(port_control_oe, 1'b1);
      $display("release test done");
   endtask
   task automatic t_wait;
      axi_wr(OFF_PORT_CTRL, 32'h0);
      axi_wr(OFF_OMR, 32'h80);
      @(posedge aclk) stall_len <= 4'h3;
      core_acc(1'b0, 24'h0);
      chk(cyc, 5);
      chk(snap[1], 1'b0);
      chk(core_rdata, 24'hC0FFE2);
      @(posedge aclk) stall_len <= 4'h0;
      axi_wr(OFF_OMR, 32'h00);
      $display("wait test done");
   endtask
   task automatic t_irq;
      axi_wr(OFF_IRQ_CFG, 32'h2);
      @(posedge aclk);
      {boot_mode_pin_b, boot_mode_pin_a} <= 2'h0;
      repeat (3) @(negedge aclk);
      chk(irq_request, 2'h3);
      @(posedge aclk);
      {boot_mode_pin_b, boot_mode_pin_a} <= 2'h3;
      repeat (3) @(negedge aclk);
      chk(irq_request, 2'h2);
      @(posedge aclk);
      irq_ack <= 2'h2;
      @(posedge aclk);
      irq_ack <= 2'h0;
      repeat (2) @(negedge aclk);
      chk({irq_request, operating_mode}, 4'h0);
      $display("interrupt test done");
   endtask
   initial begin
      repeat (5000) @(posedge aclk);
      err_total++;
      stop_test();
   end
   initial begin
      err_total = 0;
      checked = 0;
      aresetn <= 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, core_req, irq_ack} <= '0;
      {core_write, core_data_space, core_y_space, stall_len} <= '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, core_addr, core_wdata} <= '0;
      {s_axi_bready, s_axi_rready, core_instr_boundary} <= '1;
      {master_request_n, s_axi_wstrb} <= '1;
      {boot_mode_pin_b, boot_mode_pin_a} <= 2'h1;
      sp = 2'h0;
      repeat (9) @(posedge aclk);
      @(negedge aclk);
      chk({port_control_oe, bus_grant_oe, port_data_oe}, 3'h0);
      @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      {boot_mode_pin_b, boot_mode_pin_a} <= 2'h3;
      t_regs();
      t_access();
      t_release();
      t_wait();
      t_irq();
      stop_test();
   end
endmodule
`default_nettype wire
